// ==== core/pms_defs.svh ====
// Timing constants and widths of the power-mode sequencer
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

`define PMS_CLK_HZ      20000000
`define PMS_VLF_HZ      2000
`define PMS_FAST_HZ     1000000
`define PMS_INSTR_CLKS  4
`define PMS_STEP_MS     250
`define PMS_LF_ON_US    1000
`define PMS_LF_OFF_US   9000
`define PMS_STEPS_W     8
`define PMS_IRQ_PINS    2

`define PMS_VLF_DIV     (`PMS_CLK_HZ / `PMS_VLF_HZ)
`define PMS_FAST_DIV    (`PMS_CLK_HZ / `PMS_FAST_HZ)
`define PMS_STEP_TICKS  (`PMS_STEP_MS * `PMS_VLF_HZ / 1000)
`define PMS_LF_ON_CYC   ((`PMS_CLK_HZ / 1000000) * `PMS_LF_ON_US)
`define PMS_LF_OFF_CYC  ((`PMS_CLK_HZ / 1000000) * `PMS_LF_OFF_US)

`endif

// ==== core/pms_pkg.sv ====
// Types shared by the power-mode sequencer
`default_nettype none
package pms_pkg;

    typedef enum logic [3:0] {
        PMS_SHELF = 4'b0001,
        PMS_SLEEP = 4'b0010,
        PMS_RUN   = 4'b0100,
        PMS_IDLE  = 4'b1000
    } pms_state_e;

    typedef struct packed {
        logic       strong_field;
        logic       medium_field;
        logic       motion;
        logic [1:0] io_irq;
        logic       timer;
    } pms_wake_s;

    typedef struct packed {
        logic very_low_freq_osc;
        logic fast_cpu_osc;
        logic cpu_exec;
        logic adc_on;
    } pms_clk_s;

endpackage
`default_nettype wire

// ==== core/pms_tick_div.sv ====
// Free-running divider giving a one-cycle tick while enabled
`default_nettype none
module pms_tick_div #(
    parameter int DIV = 20
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire          at_last = (cnt_r == LAST);

    assign cnt_nxt = (!run || at_last) ? '0 : cnt_r + W'(1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= run && at_last;
        end
    end
endmodule
`default_nettype wire

// ==== core/pms_sequencer.sv ====
// Power-mode sequencer: shelf, sleep, run and idle with their wake sources
// Behaviour
// - Shelf keeps everything off except reset and the strong-field, motion and interrupt-pin wakes
// - External interrupt ends shelf
// - Sleep runs only the very slow oscillator
// - Sleep counter wakes after programmed interval
// - Run means fast clock and execution
// - Idle during measurement: converter only
// - Interrupt pins wake from shelf or sleep
// - Over-temperature sleeps instead of measuring
// - Coil sensing 1 ms on, 9 ms off
// - Motion switch sensed on one interrupt input
// - Accelerometer power switched by one output
// - Slow tick 2 kHz, interval steps 250 ms
// - Fast clock 1 MHz, four clocks per instruction
// - Medium field wakes sleep when enabled
`include "pms_defs.svh"
`default_nettype none
module pms_sequencer
    import pms_pkg::*;
#(
    parameter int VLF_DIV    = `PMS_VLF_DIV,
    parameter int LF_ON_CYC  = `PMS_LF_ON_CYC,
    parameter int LF_OFF_CYC = `PMS_LF_OFF_CYC
) (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic [`PMS_IRQ_PINS-1:0] io_irq_pin,
    input  wire logic                    motion_pin,
    input  wire logic                    strong_field_pin,
    input  wire logic                    medium_field_pin,
    input  wire logic                    go_shelf,
    input  wire logic                    go_sleep,
    input  wire logic                    go_idle,
    input  wire logic                    meas_done,
    input  wire logic [`PMS_STEPS_W-1:0] sleep_steps,
    input  wire logic                    temp_above_limit,
    input  wire logic                    overtemp_sleep_en,
    input  wire logic                    medium_field_en,
    input  wire logic [`PMS_IRQ_PINS-1:0] io_irq_en,
    input  wire logic                    motion_en,
    input  wire logic                    accel_on,
    output pms_state_e                   state_r,
    output pms_clk_s                     clk_en_r,
    output logic                         lf_sense_r,
    output logic                         accel_pwr_r,
    output logic                         instr_tick_r,
    output pms_wake_s                    wake_cause_r
);
    localparam int SIG_N = `PMS_IRQ_PINS + 3;
    localparam int LF_W  = $clog2(LF_ON_CYC + LF_OFF_CYC);
    localparam int STP_W = $clog2(`PMS_STEP_TICKS);
    localparam logic [LF_W-1:0]  LF_ON_LAST  = LF_W'(LF_ON_CYC - 1);
    localparam logic [LF_W-1:0]  LF_OFF_LAST = LF_W'(LF_OFF_CYC - 1);
    localparam logic [STP_W-1:0] STEP_LAST   = STP_W'(`PMS_STEP_TICKS - 1);

    // Two-flop synchronisers; only stage two and the history flop are read
    logic [SIG_N-1:0] meta_r;
    logic [SIG_N-1:0] sync_r;
    logic [SIG_N-1:0] hist_r;
    wire  [SIG_N-1:0] pins = {strong_field_pin, medium_field_pin, motion_pin, io_irq_pin};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
            hist_r <= '0;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            hist_r <= sync_r;
        end
    end

    // Edges of the synchronised pins, so a held level wakes only once
    wire [SIG_N-1:0] rise = sync_r & ~hist_r;
    wire [`PMS_IRQ_PINS-1:0] io_evt = rise[`PMS_IRQ_PINS-1:0] & io_irq_en;
    wire motion_evt = rise[`PMS_IRQ_PINS] & motion_en;
    wire mfd_evt    = rise[`PMS_IRQ_PINS+1] & lf_sense_r;
    wire sfd_evt    = rise[`PMS_IRQ_PINS+2];

    function automatic logic in_state(input pms_state_e s, input pms_state_e q);
        in_state = (s == q);
    endfunction

    wire st_shelf = in_state(state_r, PMS_SHELF);
    wire st_sleep = in_state(state_r, PMS_SLEEP);
    wire st_run   = in_state(state_r, PMS_RUN);
    wire st_idle  = in_state(state_r, PMS_IDLE);

    // Slow-oscillator and fast-clock ticks, and the interval counter the slow tick drives
    logic vlf_tick;
    logic fast_tick;

    pms_tick_div #(.DIV(VLF_DIV)) u_vlf_div (
        .clock (clock),
        .rst_n (rst_n),
        .run   (st_sleep),
        .tick  (vlf_tick)
    );

    pms_tick_div #(.DIV(`PMS_FAST_DIV)) u_fast_div (
        .clock (clock),
        .rst_n (rst_n),
        .run   (st_run),
        .tick  (fast_tick)
    );

    logic [STP_W-1:0]        sub_r;
    logic [`PMS_STEPS_W-1:0] step_r;
    wire step_done = vlf_tick && (sub_r == STEP_LAST);
    // Zero steps wakes straight away; the interval is only coarse to one step
    wire timer_evt = st_sleep && ((step_r == sleep_steps)
                     || (step_done && (step_r + `PMS_STEPS_W'(1) == sleep_steps)));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sub_r  <= '0;
            step_r <= '0;
        end else if (!st_sleep) begin
            sub_r  <= '0;
            step_r <= '0;
        end else if (vlf_tick) begin
            sub_r  <= step_done ? '0 : sub_r + STP_W'(1);
            step_r <= step_done ? step_r + `PMS_STEPS_W'(1) : step_r;
        end
    end

    // Coil sensing window while sleeping: low duty cycle saves current
    logic [LF_W-1:0] lf_cnt_r;
    logic            lf_sense_nxt;
    logic [LF_W-1:0] lf_cnt_nxt;
    wire lf_allowed = st_sleep && medium_field_en;
    wire lf_flip    = lf_sense_r ? (lf_cnt_r == LF_ON_LAST) : (lf_cnt_r == LF_OFF_LAST);

    assign lf_sense_nxt = lf_allowed && (lf_flip ? !lf_sense_r : lf_sense_r);
    assign lf_cnt_nxt   = (!lf_allowed || lf_flip) ? '0 : lf_cnt_r + LF_W'(1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lf_cnt_r   <= '0;
            lf_sense_r <= 1'b0;
        end else begin
            lf_cnt_r   <= lf_cnt_nxt;
            lf_sense_r <= lf_sense_nxt;
        end
    end

    // Wake decisions
    wire shelf_wake = sfd_evt || motion_evt || (|io_evt);
    wire sleep_wake = shelf_wake || mfd_evt || timer_evt;
    wire hot_skip   = overtemp_sleep_en && temp_above_limit && go_idle;

    pms_state_e state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PMS_SHELF: if (shelf_wake) state_nxt = PMS_RUN;
            PMS_SLEEP: if (sleep_wake) state_nxt = PMS_RUN;
            PMS_RUN: begin
                if (go_shelf) state_nxt = PMS_SHELF;
                else if (go_sleep || hot_skip) state_nxt = PMS_SLEEP;
                else if (go_idle) state_nxt = PMS_IDLE;
            end
            PMS_IDLE:  if (meas_done) state_nxt = PMS_RUN;
            default:   state_nxt = PMS_RUN;
        endcase
    end

    pms_wake_s wake_nxt;
    assign wake_nxt = '{strong_field: sfd_evt, medium_field: mfd_evt && st_sleep,
                        motion: motion_evt, io_irq: io_evt, timer: timer_evt};

    pms_clk_s clk_nxt;
    assign clk_nxt = '{very_low_freq_osc: (state_nxt == PMS_SLEEP),
                       fast_cpu_osc:      (state_nxt == PMS_RUN),
                       cpu_exec:          (state_nxt == PMS_RUN),
                       adc_on:            (state_nxt == PMS_IDLE)};

    logic [1:0] instr_cnt_r;
    wire instr_end = fast_tick && (instr_cnt_r == 2'(`PMS_INSTR_CLKS - 1));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= PMS_RUN;
            clk_en_r     <= '{very_low_freq_osc: 1'b0, fast_cpu_osc: 1'b1,
                              cpu_exec: 1'b1, adc_on: 1'b0};
            accel_pwr_r  <= 1'b0;
            wake_cause_r <= '0;
            instr_cnt_r  <= '0;
            instr_tick_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            clk_en_r     <= clk_nxt;
            // Sensor supply dropped in shelf so nothing draws current there
            accel_pwr_r  <= accel_on && (state_nxt != PMS_SHELF);
            if ((st_shelf || st_sleep) && state_nxt == PMS_RUN)
                wake_cause_r <= wake_nxt;
            instr_cnt_r  <= !st_run ? 2'(0) : (fast_tick ? instr_cnt_r + 2'(1) : instr_cnt_r);
            instr_tick_r <= st_run && instr_end;
        end
    end

    a_one_state: assert property (@(posedge clock) disable iff (!rst_n)
        $onehot(state_r)) else $error("state not one-hot");
    a_shelf_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        st_shelf |-> (clk_en_r == '0 && !lf_sense_r && !accel_pwr_r))
        else $error("activity in shelf");
    a_sleep_clocks: assert property (@(posedge clock) disable iff (!rst_n)
        st_sleep |-> (clk_en_r.very_low_freq_osc && !clk_en_r.fast_cpu_osc && !clk_en_r.adc_on))
        else $error("wrong clocks in sleep");
    a_timer_wake: assert property (@(posedge clock) disable iff (!rst_n)
        (st_sleep && sleep_steps == '0) |=> st_run && wake_cause_r.timer)
        else $error("zero interval did not wake");
    a_run_exec: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en_r.cpu_exec == st_run) else $error("execution not tied to run");
    a_idle_adc: assert property (@(posedge clock) disable iff (!rst_n)
        (st_run && go_idle && !go_shelf && !go_sleep && !hot_skip) |=>
        st_idle && clk_en_r.adc_on && !clk_en_r.cpu_exec) else $error("idle entry wrong");
    a_pin_wake: assert property (@(posedge clock) disable iff (!rst_n)
        ((st_shelf || st_sleep) && (|io_evt)) |=> st_run) else $error("pin did not wake");
    a_hot_sleep: assert property (@(posedge clock) disable iff (!rst_n)
        (st_run && hot_skip && !go_shelf) |=> st_sleep) else $error("hot measure not skipped");
    // Leaving sleep or clearing medium_field_en may cut the window; otherwise it must run its full on count
    a_lf_window: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(lf_sense_r) |-> ($past(lf_cnt_r) == LF_ON_LAST || !$past(lf_allowed)))
        else $error("coil window cut short");
    a_mfd_wake: assert property (@(posedge clock) disable iff (!rst_n)
        (st_sleep && mfd_evt) |=> st_run ##0 wake_cause_r.medium_field)
        else $error("medium field did not wake");
    a_instr_run: assert property (@(posedge clock) disable iff (!rst_n)
        instr_tick_r |-> ##1 !instr_tick_r [*3]) else $error("instruction tick too fast");
endmodule
`default_nettype wire

// ==== verification/pms_far_side.sv ====
// Far-side model: motion switch and coil field sources driving the wake pins
`default_nettype none
module pms_far_side (
    input  wire logic       clock,
    input  wire logic [4:0] fire,
    output var  logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bit order {strong, medium, motion, io1, io0}; open source idles low
    logic [1:0] hold_r [5];
    initial begin
        pins = 5'h00;
        for (int i = 0; i < 5; i++) hold_r[i] = 2'h0;
    end
    // Short closure of a switch or burst of field, then release
    always @(posedge clock) begin
        for (int i = 0; i < 5; i++) begin
            if (fire[i]) begin
                pins[i] <= 1'b1;
                hold_r[i] <= 2'h3;
            end else if (hold_r[i] != 2'h0) begin
                hold_r[i] <= hold_r[i] - 2'h1;
                pins[i] <= (hold_r[i] != 2'h1);
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/power_mode_sequencer_test.sv ====
// Self-checking bench for the power-mode sequencer
`default_nettype none
module power_mode_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pms_pkg::*;
    logic clock = 0, rst_n = 0, go_shelf = 0, go_sleep = 0, go_idle = 0, meas_done = 0;
    logic temp_above_limit = 0, overtemp_sleep_en = 0, medium_field_en = 0, accel_on = 0;
    logic [7:0] sleep_steps = 8'h00;
    logic [1:0] io_irq_en = 2'h3;
    logic       motion_en = 1'b1;
    logic [4:0] fire = 5'h00, pins;
    pms_state_e state_r;
    pms_clk_s   clk_en_r;
    pms_wake_s  wake_cause_r;
    logic       lf_sense_r, accel_pwr_r, instr_tick_r;
    int         n_fail = 0, n_checks = 0, n;
    always #25 clock = ~clock;
    pms_far_side i_pms_far_side (.clock(clock), .fire(fire), .pins(pins));
    pms_sequencer #(.VLF_DIV(4), .LF_ON_CYC(8), .LF_OFF_CYC(16)) i_pms_sequencer (
        .clock(clock), .rst_n(rst_n), .io_irq_pin(pins[1:0]), .motion_pin(pins[2]),
        .strong_field_pin(pins[4]), .medium_field_pin(pins[3]), .go_shelf(go_shelf),
        .go_sleep(go_sleep), .go_idle(go_idle), .meas_done(meas_done),
        .sleep_steps(sleep_steps), .temp_above_limit(temp_above_limit),
        .overtemp_sleep_en(overtemp_sleep_en), .medium_field_en(medium_field_en),
        .io_irq_en(io_irq_en), .motion_en(motion_en), .accel_on(accel_on), .state_r(state_r),
        .clk_en_r(clk_en_r), .lf_sense_r(lf_sense_r), .accel_pwr_r(accel_pwr_r),
        .instr_tick_r(instr_tick_r), .wake_cause_r(wake_cause_r));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
        @(negedge clock);
    endtask
    task automatic fire_src(input int i);
        fire[i] = 1'b1;
        @(negedge clock);
        fire = 5'h00;
    endtask
    // Bounded wait for a state, then state and clock enables compared
    task automatic expect_state(input logic [3:0] s, input logic [3:0] c, input int max);
        n = 0;
        while (state_r !== s && n < max) begin
            @(negedge clock);
            n++;
        end
        chk(state_r, s);
        chk(clk_en_r, c);
    endtask
    task automatic t_run;
        expect_state(4'h4, 4'h6, 0);
        n = 0;
        while (instr_tick_r !== 1'b1 && n < 100) begin @(negedge clock); n++; end
        n = 0;
        do begin @(negedge clock); n++; end while (instr_tick_r !== 1'b1 && n < 100);
        chk(n, 8'h50);
        $display("test run done");
    endtask
    task automatic t_idle;
        pulse(meas_done);
        expect_state(4'h4, 4'h6, 0);
        pulse(go_idle);
        expect_state(4'h8, 4'h1, 0);
        pulse(meas_done);
        expect_state(4'h4, 4'h6, 0);
        $display("test idle done");
    endtask
    task automatic t_timer;
        sleep_steps = 8'h01;
        pulse(go_sleep);
        expect_state(4'h2, 4'h8, 0);
        expect_state(4'h4, 4'h6, 2100);
        chk({7'h00, n > 1980}, 8'h01);
        chk(wake_cause_r, 8'h01);
        $display("test timer done");
    endtask
    task automatic t_hot;
        temp_above_limit = 1'b1;
        overtemp_sleep_en = 1'b1;
        sleep_steps = 8'h00;
        go_idle = 1'b1;
        @(negedge clock);
        go_idle = 1'b0;
        chk(state_r, 8'h02);
        chk(clk_en_r, 8'h08);
        expect_state(4'h4, 4'h6, 8);
        chk(wake_cause_r, 8'h01);
        temp_above_limit = 1'b0;
        pulse(go_idle);
        expect_state(4'h8, 4'h1, 0);
        pulse(meas_done);
        $display("test hot done");
    endtask
    task automatic t_shelf;
        accel_on = 1'b1;
        @(negedge clock);
        @(negedge clock);
        chk(accel_pwr_r, 8'h01);
        pulse(go_shelf);
        expect_state(4'h1, 4'h0, 0);
        chk(accel_pwr_r, 8'h00);
        pulse(go_idle);
        expect_state(4'h1, 4'h0, 0);
        fire_src(2);
        expect_state(4'h4, 4'h6, 8);
        chk(wake_cause_r, 8'h08);
        pulse(go_shelf);
        fire_src(4);
        expect_state(4'h4, 4'h6, 8);
        chk(wake_cause_r, 8'h20);
        $display("test shelf done");
    endtask
    task automatic t_pins;
        sleep_steps = 8'hFF;
        io_irq_en = 2'h1;
        motion_en = 1'b0;
        pulse(go_sleep);
        fire_src(1);
        fire_src(2);
        fire_src(3);
        repeat (8) @(negedge clock);
        chk(state_r, 8'h02);
        io_irq_en = 2'h3;
        motion_en = 1'b1;
        fire_src(1);
        expect_state(4'h4, 4'h6, 8);
        chk(wake_cause_r, 8'h04);
        medium_field_en = 1'b1;
        pulse(go_sleep);
        n = 0;
        while (lf_sense_r !== 1'b1 && n < 40) begin @(negedge clock); n++; end
        chk(lf_sense_r, 8'h01);
        fire_src(3);
        expect_state(4'h4, 4'h6, 8);
        chk(wake_cause_r, 8'h10);
        $display("test pins done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Tests need about 2250 cycles; a generous margin avoids false hangs
    initial begin
        #(20000 * 50);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        t_run();
        t_idle();
        t_timer();
        t_hot();
        t_shelf();
        t_pins();
        final_report();
    end
endmodule
`default_nettype wire
